/* logic/fpx_defs.svh */
`ifndef FPX_DEFS_SVH
`define FPX_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses on the register bus).
`define FPX_OFF_SCALAR_STATUS 8'h00
`define FPX_OFF_SCALAR_CTRL 8'h04
`define FPX_OFF_SIMD_CTRL_STATUS 8'h08
`define FPX_OFF_EVENT_CAPTURE 8'h0C

// ==========================================================================
// Exception class bit positions inside a six-bit class vector.
`define FPX_NUM_CLASSES 6
`define FPX_CLS_INVALID 0
`define FPX_CLS_SUBNORMAL 1
`define FPX_CLS_DIV_NIL 2
`define FPX_CLS_OVERFLOW 3
`define FPX_CLS_UNDERFLOW 4
`define FPX_CLS_INEXACT 5

// ==========================================================================
// Field positions in the registers.
`define FPX_SCALAR_FLAG_LSB 0
`define FPX_SCALAR_MASK_LSB 0
`define FPX_SIMD_FLAG_LSB 0
`define FPX_SIMD_MASK_LSB 7
`define FPX_CAP_ENV_BIT 8
`define FPX_CAP_COUNT_LSB 16

// ==========================================================================
// Reset values: all classes masked, no flags recorded.
`define FPX_FLAGS_RESET 6'h00
`define FPX_MASKS_RESET 6'h3F

// ==========================================================================
// Single-precision encodings used for default results.
`define FPX_INDEFINITE 32'hFFC0_0000
`define FPX_QUIET_BIT 22
`define FPX_EXP_ALL_ONES 8'hFF

`endif

/* logic/fpx_pkg.sv */
package fpx_pkg;

  // Arithmetic operation presented to the unit.
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} op_kind_t;

  // Floating-point environment that executed the operation.
  typedef enum logic {ENV_SCALAR, ENV_SIMD} fp_env_t;

  // One bit per exception class.
  typedef logic [5:0] exc_vec_t;

endpackage

/* logic/fpx_precheck.sv */
`timescale 1ns/1ns
`include "fpx_defs.svh"

module fpx_precheck (
  input wire logic [31:0] op_a_i, // First operand, single precision.
  input wire logic [31:0] op_b_i, // Second operand, single precision.
  input wire fpx_pkg::op_kind_t kind_i, // Operation kind.
  output logic invalid_o, // Invalid operation before arithmetic.
  output logic subnormal_o, // An operand is denormal.
  output logic div_nil_o, // Finite non-zero divided by zero.
  output logic [31:0] nan_result_o, // Quiet NaN to deliver when invalid.
  output logic inf_sign_o // Sign of the infinity for division by zero.
);
  import fpx_pkg::*;

  logic [1:0] is_zero;
  logic [1:0] is_subn;
  logic [1:0] is_inf;
  logic [1:0] is_snan;
  logic [1:0] is_nan;
  logic [31:0] opnd [2];

  assign opnd[0] = op_a_i;
  assign opnd[1] = op_b_i;

  // ========================================================================
  // Operand classification, one copy per operand.
  for (genvar i = 0; i < 2; i++) begin : g_cls
    logic exp_max;
    logic exp_nil;
    logic frac_nil;
    assign exp_max = (opnd[i][30:23] == `FPX_EXP_ALL_ONES);
    assign exp_nil = (opnd[i][30:23] == 8'h00);
    assign frac_nil = (opnd[i][22:0] == 23'h00_0000);
    assign is_zero[i] = exp_nil & frac_nil;
    assign is_subn[i] = exp_nil & ~frac_nil;
    assign is_inf[i] = exp_max & frac_nil;
    assign is_nan[i] = exp_max & ~frac_nil;
    assign is_snan[i] = is_nan[i] & ~opnd[i][`FPX_QUIET_BIT];
  end

  // ========================================================================
  // Pre-computation checks; the datapath result is not consulted here.
  always_comb begin
    logic eff_sub;
    eff_sub = (op_a_i[31] ^ op_b_i[31]) ^ (kind_i == OP_SUB);
    invalid_o = |is_snan;
    case (kind_i)
      OP_ADD, OP_SUB: invalid_o = invalid_o | (&is_inf & eff_sub);
      OP_MUL: invalid_o = invalid_o | (is_zero[0] & is_inf[1]) | (is_inf[0] & is_zero[1]);
      OP_DIV: invalid_o = invalid_o | (&is_zero) | (&is_inf);
      default: invalid_o = invalid_o;
    endcase
    subnormal_o = |is_subn;
    div_nil_o = (kind_i == OP_DIV) & is_zero[1] & ~is_zero[0] & ~is_inf[0] & ~is_nan[0];
    inf_sign_o = op_a_i[31] ^ op_b_i[31];
    // A signalling NaN operand is quieted and passed on; otherwise indefinite.
    if (is_snan[0]) begin
      nan_result_o = op_a_i | (32'h0000_0001 << `FPX_QUIET_BIT);
    end else if (is_snan[1]) begin
      nan_result_o = op_b_i | (32'h0000_0001 << `FPX_QUIET_BIT);
    end else begin
      nan_result_o = `FPX_INDEFINITE;
    end
  end

endmodule // fpx_precheck

/* logic/fp_exception_flag_mask_unit.sv */
// Functional notes
// - Six exception classes are recognised: invalid, divide, denormal, overflow, underflow, inexact.
// - Invalid, divide and denormal are checked before arithmetic; the rest after.
// - Flags of all detected classes are set first; masks then pick the response.
// - Masked classes deliver a default result and continue; unmasked classes raise handler.
// - Flags are sticky and accumulate until software clears them.
// - Scalar flags sit in status bits 0-5; scalar masks in control bits 0-5.
// - SIMD flags sit in bits 0-5, masks in bits 7-12 of one register.
// - Scalar and SIMD sets record and control only their own environment.
// - Masked responses continue the instruction, so several classes may flag together.
// - Masked invalid sets its flag and writes indefinite or a quiet NaN.
// - Unmasked invalid sets its flag, raises the handler, leaves operands untouched.
// - Masked denormal sets its flag and completes using the denormal value.
// - Unmasked denormal sets its flag, raises the handler, leaves operands untouched.
// - Divide-by-zero is a finite non-zero dividend over a zero divisor.
// - Masked divide-by-zero sets its flag and returns infinity signed by sign XOR.
// - Unmasked divide-by-zero sets its flag, raises handler, leaves operands untouched.
`timescale 1ns/1ns
`include "fpx_defs.svh"

module fp_exception_flag_mask_unit #(
  parameter int ADR_W = 8 // Byte address width of the register bus.
) (
  input wire logic clk_i, // Core clock, 25 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  // Wishbone classic slave.
  input wire logic cyc_i, // Bus cycle.
  input wire logic stb_i, // Strobe.
  input wire logic we_i, // Write enable.
  input wire logic [ADR_W-1:0] adr_i, // Byte address.
  input wire logic [3:0] sel_i, // Byte lane selects.
  input wire logic [31:0] dat_i, // Write data.
  output logic [31:0] dat_o, // Read data.
  output logic ack_o, // Acknowledge.
  // Operation report from the arithmetic datapath.
  input wire logic op_valid_i, // One cycle per instruction.
  input wire fpx_pkg::fp_env_t op_env_i, // Environment of the instruction.
  input wire fpx_pkg::op_kind_t op_kind_i, // Operation kind.
  input wire logic [31:0] op_a_i, // First operand.
  input wire logic [31:0] op_b_i, // Second operand.
  input wire logic [31:0] calc_result_i, // Rounded datapath result.
  input wire logic calc_overflow_i, // Post-computation overflow.
  input wire logic calc_underflow_i, // Post-computation underflow.
  input wire logic calc_inexact_i, // Post-computation inexact.
  // Response to the core.
  output logic done_o, // Pulse: response for one instruction.
  output logic [31:0] result_o, // Value for the destination register.
  output logic result_we_o, // Destination may be written.
  output logic handler_o, // Pulse: invoke the software handler.
  output fpx_pkg::exc_vec_t detected_o // Classes detected in this instruction.
);
  import fpx_pkg::*;

  // ========================================================================
  // Declarations.
  exc_vec_t scalar_flags_q;
  exc_vec_t scalar_flags_d;
  exc_vec_t scalar_masks_q;
  exc_vec_t simd_flags_q;
  exc_vec_t simd_flags_d;
  exc_vec_t simd_masks_q;
  exc_vec_t cap_cls_q;
  fp_env_t cap_env_q;
  logic [7:0] handler_count_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic done_q;
  logic [31:0] result_q;
  logic result_we_q;
  logic handler_q;
  exc_vec_t detected_q;

  logic pre_invalid;
  logic pre_subnormal;
  logic pre_div_nil;
  logic [31:0] nan_result;
  logic inf_sign;

  exc_vec_t env_masks;
  exc_vec_t pre_cls;
  exc_vec_t post_cls;
  exc_vec_t det_cls;
  logic pre_unmasked;
  logic raise_handler;
  logic [31:0] resp_value;

  logic bus_req;
  logic bus_write;
  logic [31:0] lane_mask;
  logic hit_scalar_status;
  logic hit_scalar_ctrl;
  logic hit_simd;
  logic hit_capture;
  logic [31:0] simd_word;

  // ========================================================================
  // Pre-computation operand checks.
  fpx_precheck fpx_precheck_inst (
    .op_a_i(op_a_i),
    .op_b_i(op_b_i),
    .kind_i(op_kind_i),
    .invalid_o(pre_invalid),
    .subnormal_o(pre_subnormal),
    .div_nil_o(pre_div_nil),
    .nan_result_o(nan_result),
    .inf_sign_o(inf_sign)
  );

  // ========================================================================
  // Exception detection and response selection.

  // The mask set follows the environment that ran the instruction.
  assign env_masks = (op_env_i == ENV_SIMD) ? simd_masks_q : scalar_masks_q;

  // Classes found before any arithmetic takes place.
  always_comb begin
    pre_cls = '0;
    pre_cls[`FPX_CLS_INVALID] = pre_invalid;
    pre_cls[`FPX_CLS_SUBNORMAL] = pre_subnormal;
    pre_cls[`FPX_CLS_DIV_NIL] = pre_div_nil;
  end

  // An unmasked early class stops the instruction before arithmetic.
  assign pre_unmasked = |(pre_cls & ~env_masks);

  // Post-computation classes only count when the arithmetic really ran: no
  // unmasked early class and no masked invalid or divide default result.
  // A masked denormal lets the computation go on, so underflow or inexact
  // may follow it in the same instruction.
  always_comb begin
    post_cls = '0;
    if (!pre_unmasked && !pre_invalid && !pre_div_nil) begin
      post_cls[`FPX_CLS_OVERFLOW] = calc_overflow_i;
      post_cls[`FPX_CLS_UNDERFLOW] = calc_underflow_i;
      post_cls[`FPX_CLS_INEXACT] = calc_inexact_i;
    end
  end

  assign det_cls = op_valid_i ? (pre_cls | post_cls) : '0;

  // Any detected class with its mask clear calls the handler.
  assign raise_handler = |(det_cls & ~env_masks);

  // Default results for masked early classes; otherwise the datapath value,
  // which for a masked denormal was computed from the denormal itself.
  always_comb begin
    if (pre_invalid) begin
      resp_value = nan_result;
    end else if (pre_div_nil) begin
      resp_value = {inf_sign, `FPX_EXP_ALL_ONES, 23'h00_0000};
    end else begin
      resp_value = calc_result_i;
    end
  end

  // Registered response; nothing is written back when the handler is called
  // so the operands and destination stay as they were.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      result_q <= 32'h0000_0000;
      result_we_q <= 1'b0;
      handler_q <= 1'b0;
      detected_q <= '0;
    end else begin
      done_q <= op_valid_i;
      handler_q <= op_valid_i & raise_handler;
      result_we_q <= op_valid_i & ~raise_handler;
      detected_q <= det_cls;
      if (op_valid_i) begin
        result_q <= resp_value;
      end
    end
  end

  // ========================================================================
  // Register bus decode.

  // Requests are acknowledged one cycle after they appear; a write commits
  // at the edge where the master sees ack high.
  assign bus_req = cyc_i & stb_i;
  assign bus_write = bus_req & we_i & ack_q;

  assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  assign hit_scalar_status = (adr_i == ADR_W'(`FPX_OFF_SCALAR_STATUS));
  assign hit_scalar_ctrl = (adr_i == ADR_W'(`FPX_OFF_SCALAR_CTRL));
  assign hit_simd = (adr_i == ADR_W'(`FPX_OFF_SIMD_CTRL_STATUS));
  assign hit_capture = (adr_i == ADR_W'(`FPX_OFF_EVENT_CAPTURE));

  // Combined SIMD control and status word as software sees it.
  always_comb begin
    simd_word = 32'h0000_0000;
    simd_word[`FPX_SIMD_FLAG_LSB +: `FPX_NUM_CLASSES] = simd_flags_q;
    simd_word[`FPX_SIMD_MASK_LSB +: `FPX_NUM_CLASSES] = simd_masks_q;
  end

  // Acknowledge for one cycle per request; unmapped addresses also answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Read data is captured when the request is first seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      if (hit_scalar_status) begin
        rdata_q[`FPX_SCALAR_FLAG_LSB +: `FPX_NUM_CLASSES] <= scalar_flags_q;
      end else if (hit_scalar_ctrl) begin
        rdata_q[`FPX_SCALAR_MASK_LSB +: `FPX_NUM_CLASSES] <= scalar_masks_q;
      end else if (hit_simd) begin
        rdata_q <= simd_word;
      end else if (hit_capture) begin
        rdata_q[5:0] <= cap_cls_q;
        rdata_q[`FPX_CAP_ENV_BIT] <= (cap_env_q == ENV_SIMD);
        rdata_q[`FPX_CAP_COUNT_LSB +: 8] <= handler_count_q;
      end
    end
  end

  // ========================================================================
  // Sticky flags. A software write replaces the selected bits; a class that
  // is detected in the same cycle is still recorded, so set beats clear.
  always_comb begin
    logic [31:0] wr_scalar;
    logic [31:0] wr_simd;
    wr_scalar = 32'h0000_0000;
    wr_simd = 32'h0000_0000;
    scalar_flags_d = scalar_flags_q;
    simd_flags_d = simd_flags_q;
    if (bus_write && hit_scalar_status) begin
      wr_scalar[`FPX_SCALAR_FLAG_LSB +: `FPX_NUM_CLASSES] = scalar_flags_q;
      wr_scalar = (wr_scalar & ~lane_mask) | (dat_i & lane_mask);
      scalar_flags_d = wr_scalar[`FPX_SCALAR_FLAG_LSB +: `FPX_NUM_CLASSES];
    end
    if (bus_write && hit_simd) begin
      wr_simd = (simd_word & ~lane_mask) | (dat_i & lane_mask);
      simd_flags_d = wr_simd[`FPX_SIMD_FLAG_LSB +: `FPX_NUM_CLASSES];
    end
    if (op_env_i == ENV_SCALAR) begin
      scalar_flags_d = scalar_flags_d | det_cls;
    end else begin
      simd_flags_d = simd_flags_d | det_cls;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scalar_flags_q <= `FPX_FLAGS_RESET;
      simd_flags_q <= `FPX_FLAGS_RESET;
    end else begin
      scalar_flags_q <= scalar_flags_d;
      simd_flags_q <= simd_flags_d;
    end
  end

  // ========================================================================
  // Mask bits; they reset to all masked so a fresh core never traps.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scalar_masks_q <= `FPX_MASKS_RESET;
      simd_masks_q <= `FPX_MASKS_RESET;
    end else if (bus_write) begin
      if (hit_scalar_ctrl) begin
        scalar_masks_q <= (scalar_masks_q & ~lane_mask[5:0]) |
                          (dat_i[`FPX_SCALAR_MASK_LSB +: `FPX_NUM_CLASSES] & lane_mask[5:0]);
      end
      if (hit_simd) begin
        simd_masks_q <= (simd_masks_q & ~lane_mask[`FPX_SIMD_MASK_LSB +: `FPX_NUM_CLASSES]) |
                        (dat_i[`FPX_SIMD_MASK_LSB +: `FPX_NUM_CLASSES] &
                         lane_mask[`FPX_SIMD_MASK_LSB +: `FPX_NUM_CLASSES]);
      end
    end
  end

  // ========================================================================
  // Capture of the last instruction that raised any class, plus a wrapping
  // count of handler requests for software diagnostics.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_cls_q <= '0;
      cap_env_q <= ENV_SCALAR;
    end else if (|det_cls) begin
      cap_cls_q <= det_cls;
      cap_env_q <= op_env_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      handler_count_q <= 8'h00;
    end else if (op_valid_i && raise_handler) begin
      handler_count_q <= handler_count_q + 8'h01;
    end
  end

  // ========================================================================
  // Outputs, each straight from a flip-flop.
  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign done_o = done_q;
  assign result_o = result_q;
  assign result_we_o = result_we_q;
  assign handler_o = handler_q;
  assign detected_o = detected_q;

endmodule // fp_exception_flag_mask_unit

/* test/fpx_unit_checker.sv */
`timescale 1ns/1ns
module fpx_unit_checker (
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic cyc_i, // Bus cycle.
  input wire logic stb_i, // Bus strobe.
  input wire logic ack_o, // Bus acknowledge.
  input wire logic op_valid_i, // Instruction report.
  input wire fpx_pkg::op_kind_t op_kind_i, // Operation kind.
  input wire logic [31:0] op_a_i, // First operand.
  input wire logic [31:0] op_b_i, // Second operand.
  input wire logic calc_overflow_i, // Datapath overflow.
  input wire logic calc_underflow_i, // Datapath underflow.
  input wire logic calc_inexact_i, // Datapath inexact.
  input wire logic done_o, // Response pulse.
  input wire logic [31:0] result_o, // Destination value.
  input wire logic result_we_o, // Destination write.
  input wire logic handler_o, // Handler pulse.
  input wire fpx_pkg::exc_vec_t detected_o // Classes detected.
);
  import fpx_pkg::*;

  // ==========================================================================
  // Timing and named steps.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // A finite non-zero normal dividend over a zero divisor.
  sequence div_nil_op;
    op_valid_i && op_kind_i == OP_DIV && op_b_i[30:0] == 31'h0 &&
      op_a_i[30:23] inside {[8'h01:8'hFE]};
  endsequence
  // Normal operands only, so no early class can arise and post classes count.
  sequence clean_add;
    op_valid_i && op_kind_i == OP_ADD && op_a_i[30:23] inside {[8'h01:8'hFE]} &&
      op_b_i[30:23] inside {[8'h01:8'hFE]};
  endsequence

  // ==========================================================================
  // Assertions.
  ack_answer_a: assert property (bus_req |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  done_answer_a: assert property (op_valid_i |=> done_o) else $error("no response");
  done_cause_a: assert property (
    !op_valid_i |=> !done_o && !handler_o && detected_o == 6'h0)
    else $error("response without instruction");
  handler_cause_a: assert property (
    handler_o |-> detected_o != 6'h0 && !result_we_o)
    else $error("handler without class");
  masked_write_a: assert property (
    done_o && !handler_o |-> result_we_o)
    else $error("masked response not written");
  div_detect_a: assert property (
    div_nil_op |=> detected_o[2])
    else $error("divide by zero missed");
  div_sign_a: assert property (
    div_nil_op |=> !result_we_o ||
    result_o == {$past(op_a_i[31]) ^ $past(op_b_i[31]), 31'h7F80_0000})
    else $error("bad infinity");
  post_ovf_a: assert property (
    clean_add ##0 calc_overflow_i |=> detected_o[3])
    else $error("overflow missed");
  clean_quiet_a: assert property (
    clean_add ##0 !calc_overflow_i && !calc_underflow_i && !calc_inexact_i |=>
    detected_o == 6'h0)
    else $error("false class");
  result_hold_a: assert property (
    !op_valid_i |=> $stable(result_o))
    else $error("result moved");
endmodule // fpx_unit_checker

bind fp_exception_flag_mask_unit fpx_unit_checker fpx_unit_checker_inst (.clk_i, .rst_i,
  .cyc_i, .stb_i, .ack_o, .op_valid_i, .op_kind_i, .op_a_i, .op_b_i, .calc_overflow_i,
  .calc_underflow_i, .calc_inexact_i, .done_o, .result_o, .result_we_o, .handler_o,
  .detected_o);

/* test/fp_exception_flag_mask_unit_test.sv */
`timescale 1ns/1ns
`include "fpx_defs.svh"
module fp_exception_flag_mask_unit_test;
  import fpx_pkg::*;
  typedef struct {exc_vec_t det; logic hnd; logic care; logic [31:0] res;} op_note_t;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic op_valid_i = 1'b0, calc_overflow_i = 1'b0, calc_underflow_i = 1'b0;
  logic calc_inexact_i = 1'b0, ack_o, done_o, result_we_o, handler_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, op_a_i = 32'h0, op_b_i = 32'h0, calc_result_i = 32'h0;
  logic [31:0] dat_o, result_o;
  fp_env_t op_env_i = ENV_SCALAR;
  op_kind_t op_kind_i = OP_ADD;
  exc_vec_t detected_o;
  exc_vec_t fl [2];
  exc_vec_t mk [2];
  logic [31:0] cap_m = 32'h0000_0000; // Expected image of the capture register.
  int n_errors = 0, compares = 0, seed = 80616;
  op_note_t op_q [$];
  op_note_t note;
  logic [31:0] rd_q [$];

  fp_exception_flag_mask_unit fp_exception_flag_mask_unit_inst (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .op_valid_i, .op_env_i,
    .op_kind_i, .op_a_i, .op_b_i, .calc_result_i, .calc_overflow_i, .calc_underflow_i,
    .calc_inexact_i, .done_o, .result_o, .result_we_o, .handler_o, .detected_o);

  // Free-running 25 MHz core clock.
  always #20 clk_i = ~clk_i;

  // ==========================================================================
  // Comparison, verdict and the expected register image.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] reg_val(input logic [7:0] a);
    case (a)
      `FPX_OFF_SCALAR_STATUS: return {26'h0, fl[0]};
      `FPX_OFF_SCALAR_CTRL: return {26'h0, mk[0]};
      `FPX_OFF_SIMD_CTRL_STATUS: return {19'h0, mk[1], 1'b0, fl[1]};
      `FPX_OFF_EVENT_CAPTURE: return cap_m;
      default: return 32'h0;
    endcase
  endfunction

  // ==========================================================================
  // Drivers. Requests change just after an edge and stay until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) begin
      n_errors++;
      results();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    rd_q.push_back(reg_val(a));
    wb(1'b0, a, 4'hF, $random(seed));
  endtask

  // Only the selected byte lanes change; the SIMD masks straddle lanes 0 and 1.
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, a, s, d);
    if (s[0] && a == `FPX_OFF_SCALAR_STATUS) fl[0] = d[5:0];
    if (s[0] && a == `FPX_OFF_SCALAR_CTRL) mk[0] = d[5:0];
    if (s[0] && a == `FPX_OFF_SIMD_CTRL_STATUS) fl[1] = d[5:0];
    if (s[0] && a == `FPX_OFF_SIMD_CTRL_STATUS) mk[1][0] = d[7];
    if (s[1] && a == `FPX_OFF_SIMD_CTRL_STATUS) mk[1][5:1] = d[12:8];
  endtask

  // Mode m: 0 result unchecked, 1 datapath value passes, 2 default value expected.
  task automatic op(input fp_env_t e, input op_kind_t k, input logic [31:0] a,
    input logic [31:0] b, input logic [2:0] post, input exc_vec_t det, input int m,
    input logic [31:0] res);
    op_note_t n;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_env_i <= e;
    op_kind_i <= k;
    op_a_i <= a;
    op_b_i <= b;
    {calc_inexact_i, calc_underflow_i, calc_overflow_i} <= post;
    calc_result_i <= (m == 1) ? res : $random(seed);
    n.det = det;
    n.hnd = |(det & ~mk[e]);
    n.care = m != 0;
    n.res = res;
    op_q.push_back(n);
    fl[e] = fl[e] | det;
    if (n.hnd) cap_m[23:16] = cap_m[23:16] + 8'h01;
    if (det != 6'h00) cap_m[8:0] = {(e == ENV_SIMD), 2'b00, det};
  endtask

  task automatic idle();
    @(posedge clk_i);
    op_valid_i <= 1'b0;
  endtask

  // Monitor: every response takes the oldest note once the edge has settled.
  always @(posedge clk_i) begin
    #1;
    if (done_o === 1'b1 && op_q.size() > 0) begin
      note = op_q.pop_front();
      check({26'h0, detected_o}, {26'h0, note.det}, "classes");
      check({31'h0, handler_o}, {31'h0, note.hnd}, "handler");
      check({31'h0, result_we_o}, {31'h0, ~note.hnd}, "dest write");
      if (note.care) check(result_o, note.res, "result");
    end else if (done_o !== 1'b0) begin
      check({31'h0, done_o}, 32'h0, "stray response");
    end
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) begin
      check(dat_o, rd_q.pop_front(), "register read");
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] a, b;
    int i;
    fl[0] = 6'h00;
    fl[1] = 6'h00;
    mk[0] = 6'h3F;
    mk[1] = 6'h3F;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) rd(8'(i * 4));
    // Masked early and late classes in the scalar environment.
    op(ENV_SCALAR, OP_DIV, 32'h3F80_0000, 32'h8000_0000, 3'b000, 6'h04, 2, 32'hFF80_0000);
    op(ENV_SCALAR, OP_DIV, 32'hC000_0000, 32'h8000_0000, 3'b000, 6'h04, 2, 32'h7F80_0000);
    op(ENV_SCALAR, OP_DIV, 32'h0000_0000, 32'h0000_0000, 3'b001, 6'h01, 2, 32'hFFC0_0000);
    op(ENV_SCALAR, OP_DIV, 32'h7F80_0000, 32'h0000_0000, 3'b000, 6'h00, 0, 32'h0000_0000);
    op(ENV_SCALAR, OP_ADD, 32'h7F80_0001, 32'h3F80_0000, 3'b000, 6'h01, 2, 32'h7FC0_0001);
    op(ENV_SCALAR, OP_MUL, 32'h0000_0001, 32'h3F80_0000, 3'b100, 6'h22, 1, 32'h1234_5678);
    op(ENV_SCALAR, OP_ADD, 32'h3F80_0000, 32'h4000_0000, 3'b110, 6'h30, 0, 32'h0000_0000);
    op(ENV_SCALAR, OP_ADD, 32'h3F80_0000, 32'h4000_0000, 3'b001, 6'h08, 0, 32'h0000_0000);
    idle();
    rd(`FPX_OFF_SCALAR_STATUS);
    rd(`FPX_OFF_SIMD_CTRL_STATUS);
    // Scalar classes unmasked while the SIMD set stays masked.
    wr(`FPX_OFF_SCALAR_CTRL, 4'h1, 32'h0000_0000);
    op(ENV_SCALAR, OP_DIV, 32'h3F80_0000, 32'h0000_0000, 3'b000, 6'h04, 0, 32'h0000_0000);
    op(ENV_SCALAR, OP_ADD, 32'h0000_0001, 32'h3F80_0000, 3'b100, 6'h02, 0, 32'h0000_0000);
    op(ENV_SCALAR, OP_ADD, 32'h7F80_0001, 32'h3F80_0000, 3'b000, 6'h01, 0, 32'h0000_0000);
    op(ENV_SIMD, OP_DIV, 32'h3F80_0000, 32'h0000_0000, 3'b000, 6'h04, 2, 32'h7F80_0000);
    op(ENV_SCALAR, OP_SUB, 32'h3F80_0000, 32'h4000_0000, 3'b100, 6'h20, 0, 32'h0000_0000);
    idle();
    // Clearing: no lanes selected changes nothing; a lane-0 write keeps mask bit 7.
    wr(`FPX_OFF_SCALAR_STATUS, 4'h0, 32'h0000_0000);
    rd(`FPX_OFF_SCALAR_STATUS);
    wr(`FPX_OFF_SIMD_CTRL_STATUS, 4'h1, 32'h0000_1F80);
    wr(`FPX_OFF_SIMD_CTRL_STATUS, 4'h2, 32'h0000_0000);
    wr(`FPX_OFF_SCALAR_STATUS, 4'h1, 32'h0000_0000);
    wr(`FPX_OFF_SCALAR_CTRL, 4'h1, 32'h0000_003F);
    for (i = 0; i < 3; i++) rd(8'(i * 4));
    op(ENV_SIMD, OP_DIV, 32'hBF80_0000, 32'h0000_0000, 3'b000, 6'h04, 0, 32'h0000_0000);
    op(ENV_SIMD, OP_ADD, 32'h7F80_0001, 32'h3F80_0000, 3'b000, 6'h01, 2, 32'h7FC0_0001);
    idle();
    wr(8'h10, 4'hF, $random(seed));
    rd(8'h10);
    rd(`FPX_OFF_EVENT_CAPTURE);
    rd(`FPX_OFF_SIMD_CTRL_STATUS);
    // Random clean traffic, back to back, in both environments.
    for (i = 0; i < 24; i++) begin
      a = $random(seed);
      b = $random(seed);
      a[30:29] = 2'b01;
      b[30:29] = 2'b01;
      op(fp_env_t'(a[0]), op_kind_t'(b[1:0]), a, b, 3'b000, 6'h00, 1, $random(seed));
    end
    idle();
    rd(`FPX_OFF_SCALAR_STATUS);
    repeat (3) @(posedge clk_i);
    check(32'(op_q.size() + rd_q.size()), 32'h0, "missing responses");
    results();
  end
endmodule // fp_exception_flag_mask_unit_test
